// ---- logic/psrm_pkg.sv ----
package psrm_pkg;

    // timing
    localparam int unsigned CLK_FREQ_HZ     = 40_000_000;
    localparam int unsigned PULSE_MIN_MS    = 16;
    localparam int unsigned PULSE_MIN_CYC   = (CLK_FREQ_HZ / 1000) * PULSE_MIN_MS;
    localparam int unsigned RESET_HOLD_US   = 100;
    localparam int unsigned RESET_HOLD_CYC  = (CLK_FREQ_HZ / 1_000_000) * RESET_HOLD_US;
    localparam int unsigned SUSP_WARN_US    = 10;
    localparam int unsigned SUSP_WARN_CYC   = (CLK_FREQ_HZ / 1_000_000) * SUSP_WARN_US;

    // register offsets
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_EVENT  = 4'h2;
    localparam logic [3:0] REG_LEVEL  = 4'h3;

    // control register fields
    localparam int CTRL_SLEEP_REQ  = 0;
    localparam int CTRL_DISK_REQ   = 1;
    localparam int CTRL_OFF_REQ    = 2;
    localparam int CTRL_SW_RESET   = 3;
    localparam int CTRL_ALERT_WAKE = 4;
    localparam int CTRL_CPU_TRIP   = 5;
    localparam int CTRL_WDT_FIRE   = 6;
    localparam int CTRL_RAIL_LOW   = 7;
    localparam logic [7:0] CTRL_RESET_VAL = 8'h00;

    // event register bits
    localparam int EV_POWER  = 0;
    localparam int EV_RESET  = 1;
    localparam int EV_LID    = 2;
    localparam int EV_SLEEP  = 3;
    localparam int EV_PWAKE  = 4;
    localparam int EV_GWAKE  = 5;
    localparam int EV_BATLO  = 6;
    localparam int EV_THERM  = 7;
    localparam int EV_ALERT  = 8;
    localparam int EV_COUNT  = 9;

    // pin input indices
    localparam int NUM_IN     = 10;
    localparam int IN_POWER   = 0;
    localparam int IN_RSTBTN  = 1;
    localparam int IN_LID     = 2;
    localparam int IN_SLPBTN  = 3;
    localparam int IN_PWAKE   = 4;
    localparam int IN_GWAKE   = 5;
    localparam int IN_BATLO   = 6;
    localparam int IN_THERM   = 7;
    localparam int IN_ALERT   = 8;
    localparam int IN_SUPPLY  = 9;
    localparam logic [NUM_IN-1:0] IN_IDLE = 10'h3FF;

    // power states
    typedef enum logic [2:0] {
        PS_OFF, PS_ON, PS_WARN, PS_RAM, PS_DISK
    } psrm_state_t;

    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } psrm_req_t;

    // state indicator outputs
    typedef struct packed {
        logic carrierResetN;
        logic suspendPendingN;
        logic sleepRamN;
        logic sleepDiskN;
        logic softOffN;
        logic thermalShutdownN;
        logic smiN;
    } psrm_pins_t;

endpackage : psrm_pkg

// ---- logic/psrm_manager.sv ----
// Function
// - power button falling edge leaves soft-off; here a low pulse of PULSE_CYC cycles does, while supply is good
// - reset button acts on falling edge; here on its low pulse once it has lasted PULSE_CYC cycles
// - held reset button never holds reset
// - carrier reset on any listed cause
// - supply_good high means supply good
// - warn peripherals before entering suspend
// - sleep_ram_n low in suspend-to-RAM
// - sleep_disk_n low in suspend-to-disk
// - soft_off_n asserted in soft-off
// - PCIe wake leaves sleep states
// - general wake leaves sleep states
// - battery low reported as event
// - lid assertions reported as events
// - sleep button sleeps or wakes; here it only wakes from sleep states and sets its event
// - over-temp input low flags condition
// - thermal shutdown output after CPU trip
// - bus alert selectable SMI or wake
// - fast shutdown unsupported, no input
//
// Design decisions made here: the register offsets and strobed register access.
module psrm_manager
#(
    parameter int unsigned PULSE_CYC = psrm_pkg::PULSE_MIN_CYC,
    parameter int unsigned HOLD_CYC  = psrm_pkg::RESET_HOLD_CYC,
    parameter int unsigned WARN_CYC  = psrm_pkg::SUSP_WARN_CYC
)
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 clkEn,
    // register port
    input  wire psrm_pkg::psrm_req_t  regReq,
    output logic [15:0]               regRdata,
    // carrier pins, active low unless named otherwise
    input  wire logic                 power_button_n,
    input  wire logic                 reset_button_n,
    input  wire logic                 lid_switch_n,
    input  wire logic                 sleep_button_n,
    input  wire logic                 pcie_wake_n,
    input  wire logic                 general_wake_n,
    input  wire logic                 battery_low_n,
    input  wire logic                 over_temp_in_n,
    input  wire logic                 smb_alert_n,
    input  wire logic                 supply_good,
    // indicator outputs
    output psrm_pkg::psrm_pins_t      pins
);
    import psrm_pkg::*;

    // counter widths
    localparam int PW = $clog2(PULSE_CYC + 1);
    localparam int HW = $clog2(HOLD_CYC + 1);
    localparam int WW = $clog2(WARN_CYC + 1);

    // refuse counts that the timers cannot serve
    if (PULSE_CYC < 1 || HOLD_CYC < 1 || WARN_CYC < 1)
    begin : g_bad_count
        $error("psrm_manager: counts must be at least one");
    end

    // whole module state
    typedef struct packed {
        logic [NUM_IN-1:0]           s1;       // first sync stage
        logic [NUM_IN-1:0]           s2;       // second sync stage
        logic [NUM_IN-1:0]           s3;       // third sync stage
        logic [NUM_IN-1:0]           clean;    // agreed pin level
        logic [NUM_IN-1:0][PW-1:0]   width;    // low-time counters
        logic [NUM_IN-1:0]           armed;    // pulse qualified flag
        logic [EV_COUNT-1:0]         events;   // sticky event bits
        logic [7:0]                  ctrl;     // control register
        psrm_state_t                 st;       // power state
        psrm_state_t                 target;   // suspend target
        logic [WW-1:0]               warnCnt;  // suspend warning timer
        logic [HW-1:0]               holdCnt;  // reset pulse stretch
        logic [15:0]                 rdata;    // read data
        psrm_pins_t                  pins;     // registered outputs
    } psrm_reg_t;

    psrm_reg_t r_q;  // registered state
    psrm_reg_t r_d;  // next state

    // pin vector in index order
    logic [NUM_IN-1:0] pinVec;
    assign pinVec = {supply_good, smb_alert_n, over_temp_in_n, battery_low_n, general_wake_n,
                     pcie_wake_n, sleep_button_n, lid_switch_n, reset_button_n, power_button_n};

    // qualified pulses and falling edges per input
    logic [NUM_IN-1:0] qualPulse;
    logic [NUM_IN-1:0] fallEdge;

    // qualify a low pulse of at least PULSE_CYC cycles, reported once
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++)
        begin : g_qual
            assign qualPulse[gi] = !r_q.clean[gi] && !r_q.armed[gi]
                                   && (r_q.width[gi] == PW'(PULSE_CYC - 1));
            assign fallEdge[gi]  = r_q.clean[gi] && (r_q.s2[gi] == r_q.s3[gi]) && !r_q.s3[gi];
        end
    endgenerate

    // register read mux
    function automatic logic [15:0] readMux(input logic [3:0] a, input psrm_reg_t s);
        logic [15:0] v;
        v = 16'h0000;
        unique case (a)
            REG_CTRL:   v = {8'h00, s.ctrl};
            REG_STATUS: v = {13'h0000, s.st};
            REG_EVENT:  v = {7'h00, s.events};
            REG_LEVEL:  v = {6'h00, s.clean};
            default:    v = 16'h0000;
        endcase
        return v;
    endfunction : readMux

    // next-state logic
    always_comb
    begin
        logic        wakeEv;
        logic        resetCause;
        logic [EV_COUNT-1:0] newEv;
        r_d        = r_q;
        wakeEv     = 1'b0;
        resetCause = 1'b0;
        newEv      = '0;

        // three-stage sync, level changes once stages two and three agree
        r_d.s1 = pinVec;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        for (int i = 0; i < NUM_IN; i++)
        begin
            if (r_q.s2[i] == r_q.s3[i])
            begin
                r_d.clean[i] = r_q.s3[i];
            end
            // low-time counter for pulse qualification
            if (r_q.clean[i])
            begin
                r_d.width[i] = '0;
                r_d.armed[i] = 1'b0;
            end
            else if (qualPulse[i])
            begin
                r_d.armed[i] = 1'b1;
            end
            else if (!r_q.armed[i])
            begin
                r_d.width[i] = r_q.width[i] + PW'(1);
            end
        end

        // event capture, qualified pulses for buttons and lid, edges for other sources
        newEv[EV_POWER] = qualPulse[IN_POWER];
        newEv[EV_RESET] = qualPulse[IN_RSTBTN];
        newEv[EV_LID]   = qualPulse[IN_LID];
        newEv[EV_SLEEP] = qualPulse[IN_SLPBTN];
        newEv[EV_PWAKE] = fallEdge[IN_PWAKE];
        newEv[EV_GWAKE] = fallEdge[IN_GWAKE];
        newEv[EV_BATLO] = fallEdge[IN_BATLO];
        newEv[EV_THERM] = fallEdge[IN_THERM];
        newEv[EV_ALERT] = fallEdge[IN_ALERT];

        // register writes, event bits cleared by writing one, set wins
        r_d.ctrl[CTRL_SW_RESET] = 1'b0;
        if (regReq.wr)
        begin
            unique case (regReq.addr)
                REG_CTRL:  r_d.ctrl = regReq.wdata[7:0];
                REG_EVENT: r_d.events = r_q.events & ~regReq.wdata[EV_COUNT-1:0];
                default:   ;
            endcase
        end
        r_d.events = r_d.events | newEv;

        // read data valid the cycle after the strobe only
        r_d.rdata = regReq.rd ? readMux(regReq.addr, r_q) : 16'h0000;

        // wake sources out of sleep states
        wakeEv = newEv[EV_PWAKE] || newEv[EV_GWAKE] || newEv[EV_POWER]
                 || newEv[EV_SLEEP]
                 || (newEv[EV_ALERT] && r_q.ctrl[CTRL_ALERT_WAKE]);

        // power state machine
        unique case (r_q.st)
            PS_OFF:
            begin
                if (newEv[EV_POWER] && r_q.clean[IN_SUPPLY])
                    r_d.st = PS_ON;
            end
            PS_ON:
            begin
                if (r_q.ctrl[CTRL_OFF_REQ])
                begin
                    r_d.st = PS_WARN;
                    r_d.target = PS_OFF;
                    r_d.warnCnt = WW'(WARN_CYC);
                end
                else if (r_q.ctrl[CTRL_DISK_REQ])
                begin
                    r_d.st = PS_WARN;
                    r_d.target = PS_DISK;
                    r_d.warnCnt = WW'(WARN_CYC);
                end
                else if (r_q.ctrl[CTRL_SLEEP_REQ])
                begin
                    r_d.st = PS_WARN;
                    r_d.target = PS_RAM;
                    r_d.warnCnt = WW'(WARN_CYC);
                end
            end
            PS_WARN:
            begin
                // hold the warning before the suspend takes effect
                if (r_q.warnCnt == WW'(1))
                begin
                    r_d.st = r_q.target;
                    r_d.ctrl[CTRL_SLEEP_REQ] = 1'b0;
                    r_d.ctrl[CTRL_DISK_REQ]  = 1'b0;
                    r_d.ctrl[CTRL_OFF_REQ]   = 1'b0;
                end
                else
                begin
                    r_d.warnCnt = r_q.warnCnt - WW'(1);
                end
            end
            PS_RAM, PS_DISK:
            begin
                if (wakeEv)
                    r_d.st = PS_ON;
            end
            // unused codes fall back to soft-off
            default:
            begin
                r_d.st = PS_OFF;
            end
        endcase

        // reset causes; the button counts once on its qualified low pulse only, then a fixed stretch
        resetCause = qualPulse[IN_RSTBTN]
                     || fallEdge[IN_SUPPLY]
                     || r_q.ctrl[CTRL_RAIL_LOW] || r_q.ctrl[CTRL_WDT_FIRE]
                     || r_q.ctrl[CTRL_SW_RESET];
        if (resetCause)
            r_d.holdCnt = HW'(HOLD_CYC);
        else if (r_q.holdCnt != '0)
            r_d.holdCnt = r_q.holdCnt - HW'(1);

        // outputs
        r_d.pins.carrierResetN   = !(resetCause || r_q.holdCnt != '0 || !r_q.clean[IN_SUPPLY]);
        r_d.pins.suspendPendingN = (r_d.st != PS_WARN);
        r_d.pins.sleepRamN       = !(r_d.st == PS_RAM || r_d.st == PS_DISK || r_d.st == PS_OFF);
        r_d.pins.sleepDiskN      = !(r_d.st == PS_DISK || r_d.st == PS_OFF);
        r_d.pins.softOffN        = (r_d.st != PS_OFF);
        r_d.pins.thermalShutdownN = !r_q.ctrl[CTRL_CPU_TRIP];
        r_d.pins.smiN            = !(r_q.events[EV_ALERT] && !r_q.ctrl[CTRL_ALERT_WAKE]);
    end

    // state register with clock enable
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            r_q         <= '0;
            r_q.s1      <= IN_IDLE;
            r_q.s2      <= IN_IDLE;
            r_q.s3      <= IN_IDLE;
            r_q.clean   <= IN_IDLE;
            r_q.ctrl    <= CTRL_RESET_VAL;
            r_q.st      <= PS_OFF;
            r_q.target  <= PS_OFF;
            r_q.pins    <= 7'h41; // reset released, off state indicated, suspend pending and thermal shutdown also asserted
        end
        else if (clkEn)
        begin
            r_q <= r_d;
        end
    end

    // outputs straight from flip-flops; no fast-shutdown input exists
    assign regRdata = r_q.rdata;
    assign pins     = r_q.pins;

endmodule : psrm_manager

// ---- verification/psrm_properties.sv ----
module psrm_properties
#(
    parameter int unsigned HOLD_CYC = psrm_pkg::RESET_HOLD_CYC
)
(
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 reset,
    input wire logic                 clkEn,
    // register port
    input wire psrm_pkg::psrm_req_t  regReq,
    input wire logic [15:0]          regRdata,
    // supply and indicators
    input wire logic                 supply_good,
    input wire psrm_pkg::psrm_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import psrm_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [15:0] lowCnt_q; // cycles the carrier reset has been low
    logic        ctrlWr;   // write to the control register
    assign ctrlWr = clkEn && regReq.wr && (regReq.addr == REG_CTRL);
    // counts the low time of the carrier reset
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            lowCnt_q <= 16'h0000;
        else
            lowCnt_q <= pins.carrierResetN ? 16'h0000 : lowCnt_q + 16'h0001;
    end
    a_read_idle_zero: assert property (!(clkEn && regReq.rd) |=> regRdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_supply_low_reset: assert property (!supply_good |-> ##[1:8] !pins.carrierResetN)
        else $error("carrier reset missing on supply loss");
    a_reset_hold_len: assert property ($rose(pins.carrierResetN) |-> lowCnt_q >= HOLD_CYC)
        else $error("carrier reset pulse too short");
    a_ctrl_cause_reset: assert property (ctrlWr && (regReq.wdata[3] || regReq.wdata[6] || regReq.wdata[7])
        |-> ##[1:3] !pins.carrierResetN)
        else $error("carrier reset missing on control cause");
    a_warn_before_sleep: assert property ($fell(pins.sleepRamN)
        |-> $past(!pins.suspendPendingN) || $past(!pins.suspendPendingN, 2))
        else $error("suspend entered without warning");
    a_disk_needs_ram: assert property (!pins.sleepDiskN |-> !pins.sleepRamN)
        else $error("disk indicator without ram indicator");
    a_off_needs_disk: assert property (!pins.softOffN |-> !pins.sleepDiskN)
        else $error("off indicator without disk indicator");
    a_trip_on: assert property (ctrlWr && regReq.wdata[5] |-> ##[1:3] !pins.thermalShutdownN)
        else $error("thermal shutdown output not driven");
    a_trip_off: assert property (ctrlWr && !regReq.wdata[5] |-> ##[1:3] pins.thermalShutdownN)
        else $error("thermal shutdown output not released");
    a_alert_wake_mode: assert property (ctrlWr && regReq.wdata[4] |-> ##[1:3] pins.smiN)
        else $error("management interrupt in wake mode");
endmodule : psrm_properties

bind psrm_manager psrm_properties #(.HOLD_CYC(HOLD_CYC)) psrm_properties_inst (.ref_clk(ref_clk), .reset(reset),
    .clkEn(clkEn), .regReq(regReq), .regRdata(regRdata), .supply_good(supply_good), .pins(pins));

// ---- verification/psrm_carrier.sv ----
module psrm_carrier
(
    // clock
    input  wire logic       ref_clk,
    // commands from the bench
    input  wire logic [8:0] pressReq,
    input  wire logic [7:0] pressLen,
    input  wire logic       supplyOff,
    // carrier pins
    output logic [8:0]      pinN,
    output logic            supplyGood
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] holdCnt_q [9] = '{default: 8'h00}; // low cycles left per pin
    // a press holds its pin low for the asked length
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < 9; i++)
        begin
            if (pressReq[i])
                holdCnt_q[i] <= pressLen;
            else if (holdCnt_q[i] != 8'h00)
                holdCnt_q[i] <= holdCnt_q[i] - 8'h01;
        end
    end
    // released pins return to their pull-up level
    always_comb
    begin
        for (int i = 0; i < 9; i++)
            pinN[i] = (holdCnt_q[i] == 8'h00);
    end
    assign supplyGood = !supplyOff;
endmodule : psrm_carrier

// ---- verification/psrm_manager_tb_top.sv ----
module psrm_manager_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import psrm_pkg::*;
    logic        ref_clk;                                   // 40 MHz clock
    logic        reset;                                     // async reset
    logic        clkEn;                                     // clock enable
    psrm_req_t   regReq;                                    // register request
    logic [15:0] regRdata;                                  // read data
    psrm_pins_t  pins;                                      // indicators
    logic [8:0]  pressReq;                                  // press command per pin
    logic [7:0]  pressLen;                                  // press length
    logic        supplyOff;                                 // supply failure command
    logic [8:0]  pinN;                                      // carrier pin levels
    logic        supplyGood;                                // supply level
    logic [15:0] got;                                       // last read value
    int          failures = 0;                              // mismatches
    int          num_checks = 0;                            // comparisons
    int          cycles = 0;                                // elapsed cycles
    int          wakes [3] = '{IN_SLPBTN, IN_PWAKE, IN_GWAKE}; // wake source per sleep round
    int          evPins [2] = '{IN_LID, IN_BATLO};          // plain event pins
    int          causes [3] = '{CTRL_SW_RESET, CTRL_WDT_FIRE, CTRL_RAIL_LOW}; // reset causes
    // clock
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    psrm_manager #(.PULSE_CYC(8), .HOLD_CYC(4), .WARN_CYC(3)) psrm_manager_inst (.ref_clk(ref_clk), .reset(reset),
        .clkEn(clkEn), .regReq(regReq), .regRdata(regRdata), .power_button_n(pinN[IN_POWER]),
        .reset_button_n(pinN[IN_RSTBTN]), .lid_switch_n(pinN[IN_LID]), .sleep_button_n(pinN[IN_SLPBTN]),
        .pcie_wake_n(pinN[IN_PWAKE]), .general_wake_n(pinN[IN_GWAKE]), .battery_low_n(pinN[IN_BATLO]),
        .over_temp_in_n(pinN[IN_THERM]), .smb_alert_n(pinN[IN_ALERT]), .supply_good(supplyGood), .pins(pins));
    psrm_carrier psrm_carrier_inst (.ref_clk(ref_clk), .pressReq(pressReq), .pressLen(pressLen),
        .supplyOff(supplyOff), .pinN(pinN), .supplyGood(supplyGood));
    task automatic stop_test;
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    // hang guard
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            stop_test();
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regReq <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        regReq <= '{a, d, 1'b0, 1'b0};
    endtask : wr
    // read data stand one cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        regReq <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge ref_clk);
        regReq <= '{a, 16'h0000, 1'b0, 1'b0};
        #1 got = regRdata;
    endtask : rd
    // reads until the masked value matches, bounded
    task automatic poll(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        for (int i = 0; i < 60; i++)
        begin
            rd(a);
            if ((got & m) === e)
                break;
        end
        chk($sformatf("register %h", a), e, got & m);
    endtask : poll
    // pins are looked at on the falling edge, where they are settled
    task automatic waitPin(input int b, input logic e);
        @(negedge ref_clk);
        for (int i = 0; i < 40 && pins[b] !== e; i++)
            @(negedge ref_clk);
        chk($sformatf("pin %0d", b), {15'h0000, e}, {15'h0000, pins[b]});
        @(posedge ref_clk);
    endtask : waitPin
    task automatic press(input int i, input logic [7:0] len);
        @(posedge ref_clk);
        pressReq <= 9'h001 << i;
        pressLen <= len;
        @(posedge ref_clk);
        pressReq <= 9'h000;
    endtask : press
    // main sequence
    initial
    begin
        regReq = '0;
        pressReq = 9'h000;
        pressLen = 8'h00;
        supplyOff = 1'b0;
        clkEn = 1'b1;
        reset = 1'b1;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        poll(REG_CTRL, 16'hFFFF, {8'h00, CTRL_RESET_VAL});
        poll(REG_STATUS, 16'h0007, {13'h0000, PS_OFF});
        poll(4'hF, 16'hFFFF, 16'h0000);
        poll(REG_LEVEL, 16'h03FF, 16'h03FF);
        waitPin(2, 1'b0);
        supplyOff <= 1'b1;
        waitPin(6, 1'b0);
        supplyOff <= 1'b0;
        waitPin(6, 1'b1);
        press(IN_RSTBTN, 8'h3C);
        waitPin(6, 1'b0);
        waitPin(6, 1'b1);
        chk("reset button", 16'h0000, {15'h0000, pinN[IN_RSTBTN]});
        poll(REG_EVENT, 16'h0002, 16'h0002);
        press(IN_POWER, 8'h04);
        repeat (30) @(posedge ref_clk);
        poll(REG_EVENT, 16'h0001, 16'h0000);
        press(IN_POWER, 8'h0C);
        poll(REG_STATUS, 16'h0007, {13'h0000, PS_ON});
        poll(REG_EVENT, 16'h0001, 16'h0001);
        waitPin(2, 1'b1);
        waitPin(4, 1'b1);
        for (int k = 0; k < 3; k++)
        begin
            wr(REG_CTRL, (k == 1) ? 16'h0002 : 16'h0001);
            waitPin(5, 1'b0);
            poll(REG_STATUS, 16'h0007, (k == 1) ? {13'h0000, PS_DISK} : {13'h0000, PS_RAM});
            waitPin(3, k != 1);
            waitPin(4, 1'b0);
            press(wakes[k], 8'h0C);
            poll(REG_STATUS, 16'h0007, {13'h0000, PS_ON});
        end
        wr(REG_CTRL, 16'h0020);
        waitPin(1, 1'b0);
        press(IN_THERM, 8'h0C);
        poll(REG_EVENT, 16'h0080, 16'h0080);
        press(IN_ALERT, 8'h0C);
        waitPin(0, 1'b0);
        wr(REG_CTRL, 16'h0010);
        waitPin(0, 1'b1);
        waitPin(1, 1'b1);
        foreach (evPins[j])
        begin
            press(evPins[j], 8'h0C);
            poll(REG_EVENT, 16'h0001 << evPins[j], 16'h0001 << evPins[j]);
        end
        wr(REG_EVENT, 16'h01FF);
        poll(REG_EVENT, 16'h01FF, 16'h0000);
        wr(REG_CTRL, 16'h0004);
        poll(REG_STATUS, 16'h0007, {13'h0000, PS_OFF});
        waitPin(2, 1'b0);
        foreach (causes[j])
        begin
            wr(REG_CTRL, 16'h0001 << causes[j]);
            waitPin(6, 1'b0);
            wr(REG_CTRL, 16'h0000);
            waitPin(6, 1'b1);
        end
        // a write while the clock enable is low must be lost
        clkEn <= 1'b0;
        wr(REG_CTRL, 16'h0020);
        repeat (4) @(posedge ref_clk);
        clkEn <= 1'b1;
        waitPin(1, 1'b1);
        poll(REG_CTRL, 16'hFFFF, 16'h0000);
        stop_test();
    end
endmodule : psrm_manager_tb_top
